//--- hit_test_tag_recorder.sv
// hit-test tag recorder top: mode, hit tracking and record writer
`timescale 1ns/1ps
module hit_test_tag_recorder (
	// clocking
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// commands; cmdReady high means the block can take one
	input wire logic cmdValid,
	input wire hit_test_pkg::tag_op_t tagOp,
	input wire logic [hit_test_pkg::TAG_W-1:0] tagOperand,
	input wire logic modeSwitch,
	input wire hit_test_pkg::mode_t modeSel,
	input wire logic setBuffer,
	input wire logic [hit_test_pkg::ADDR_W-1:0] bufBase,
	input wire logic [31:0] bufSize,
	output logic cmdReady,
	// primitives after clip and cull
	input wire logic primValid,
	input wire logic primInClip,
	input wire logic primCulled,
	input wire logic windowPoint,
	input wire logic vertexValid,
	input wire logic [hit_test_pkg::DEPTH_W-1:0] vertexZ,
	input wire logic fbWriteReq,
	output logic fbWriteEn,
	// result array writes
	output logic wrEn,
	output logic [hit_test_pkg::ADDR_W-1:0] wrAddr,
	output logic [31:0] wrData,
	// status
	output hit_test_pkg::mode_t mode,
	output logic retValid,
	output logic [31:0] retCount,
	output logic badOpErr,
	output logic underflowErr,
	output logic overflowErr
);
	typedef enum logic [1:0] {
		S_IDLE,
		S_WRITE,
		S_APPLY
	} state_t;

	tag_stack_if ts();

	state_t state_reg, state_next;
	hit_test_pkg::mode_t mode_reg, mode_next;
	logic configured_reg, configured_next;
	logic [hit_test_pkg::ADDR_W-1:0] base_reg, base_next, ptr_reg, ptr_next;
	logic [31:0] size_reg, size_next, used_reg, used_next;
	logic [31:0] records_reg, records_next;
	logic ovf_reg, ovf_next, hit_reg, hit_next;
	logic [hit_test_pkg::SP_W+1:0] word_reg, word_next;
	logic [hit_test_pkg::SP_W+1:0] wordTotal;
	logic pendTag_reg, pendTag_next;
	hit_test_pkg::tag_op_t op_reg, op_next;
	logic [hit_test_pkg::TAG_W-1:0] opnd_reg, opnd_next;
	hit_test_pkg::mode_t newMode_reg, newMode_next;
	logic wrEn_reg, wrEn_next;
	logic [hit_test_pkg::ADDR_W-1:0] wrAddr_reg, wrAddr_next;
	logic [31:0] wrData_reg, wrData_next;
	logic retValid_reg, retValid_next;
	logic [31:0] retCount_reg, retCount_next;
	logic badOp_reg, badOp_next, under_reg, under_next, over_reg, over_next;
	logic fbEn_reg, fbEn_next;
	logic hitNow, restartDepth, inHit, accept, cmdReady_next;
	logic [hit_test_pkg::DEPTH_W-1:0] zMin, zMax;

	tag_stack u_stack (
		.clk  (clk),
		.nrst (nrst),
		.ce   (ce),
		.ts   (ts.stack)
	);

	depth_range u_depth (
		.clk         (clk),
		.nrst        (nrst),
		.ce          (ce),
		.restart     (restartDepth),
		.sampleValid (inHit && vertexValid && primInClip && !primCulled),
		.sampleZ     (vertexZ),
		.zMin        (zMin),
		.zMax        (zMax)
	);

	assign inHit = (mode_reg == hit_test_pkg::MODE_HIT);
	// culled polygons give no hit; fill style is not an input here
	assign hitNow = inHit && ((primValid && primInClip && !primCulled) || windowPoint);
	assign wordTotal = {2'b00, ts.count} + {6'h00, hit_test_pkg::HDR_WORDS};
	assign accept = cmdValid && cmdReady;

	always_comb begin
		state_next = state_reg;
		mode_next = mode_reg;
		configured_next = configured_reg;
		base_next = base_reg;
		ptr_next = ptr_reg;
		size_next = size_reg;
		used_next = used_reg;
		records_next = records_reg;
		ovf_next = ovf_reg;
		hit_next = hit_reg || hitNow;
		word_next = word_reg;
		pendTag_next = pendTag_reg;
		op_next = op_reg;
		opnd_next = opnd_reg;
		newMode_next = newMode_reg;
		wrEn_next = 1'b0;
		wrAddr_next = wrAddr_reg;
		wrData_next = wrData_reg;
		retValid_next = 1'b0;
		retCount_next = retCount_reg;
		badOp_next = 1'b0;
		under_next = ts.underflow;
		over_next = ts.overflow;
		fbEn_next = fbWriteReq && !inHit;
		restartDepth = 1'b0;
		ts.op = hit_test_pkg::OP_NONE;
		ts.operand = opnd_reg;
		ts.flush = 1'b0;
		ts.rdIndex = '0;
		unique case (state_reg)
			S_IDLE: begin
				if (accept && setBuffer) begin
					if (inHit) begin
						badOp_next = 1'b1;
					end else begin
						base_next = bufBase;
						ptr_next = bufBase;
						size_next = bufSize;
						configured_next = 1'b1;
					end
				end else if (accept && (modeSwitch || (tagOp != hit_test_pkg::OP_NONE && inHit))) begin
					pendTag_next = !modeSwitch;
					op_next = tagOp;
					opnd_next = tagOperand;
					newMode_next = modeSel;
					word_next = '0;
					state_next = (inHit && hit_reg) ? S_WRITE : S_APPLY;
				end
			end
			S_WRITE: begin
				ts.rdIndex = word_reg[hit_test_pkg::SP_W-1:0] - 7'h03;
				unique case (word_reg)
					9'h000: wrData_next = {25'h0000000, ts.count};
					9'h001: wrData_next = zMin;
					9'h002: wrData_next = zMax;
					default: wrData_next = ts.rdData;
				endcase
				if (used_reg < size_reg) begin
					wrEn_next = 1'b1;
					wrAddr_next = ptr_reg;
					ptr_next = ptr_reg + 32'h00000001;
					used_next = used_reg + 32'h00000001;
				end else begin
					ovf_next = 1'b1;
				end
				word_next = word_reg + 9'h001;
				if (word_reg + 9'h001 == wordTotal) begin
					records_next = records_reg + 32'h00000001;
					hit_next = hitNow;
					restartDepth = 1'b1;
					state_next = S_APPLY;
				end
			end
			S_APPLY: begin
				state_next = S_IDLE;
				if (pendTag_reg) begin
					ts.op = op_reg;
					badOp_next = ts.badOp;
					hit_next = hitNow;
					restartDepth = 1'b1;
				end else begin
					ts.flush = 1'b1;
					mode_next = newMode_reg;
					if (inHit) begin
						retValid_next = 1'b1;
						retCount_next = ovf_reg ? hit_test_pkg::COUNT_OVERFLOW : records_reg;
						ovf_next = 1'b0;
						ptr_next = base_reg;
					end
					if (newMode_reg == hit_test_pkg::MODE_HIT) begin
						if (!configured_reg) badOp_next = 1'b1;
						ptr_next = base_reg;
						used_next = '0;
						records_next = '0;
						ovf_next = 1'b0;
						hit_next = hitNow;
						restartDepth = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg <= S_IDLE;
			mode_reg <= hit_test_pkg::MODE_DRAW;
			configured_reg <= 1'b0;
			base_reg <= '0;
			ptr_reg <= '0;
			size_reg <= '0;
			used_reg <= '0;
			records_reg <= '0;
			ovf_reg <= 1'b0;
			hit_reg <= 1'b0;
			word_reg <= '0;
			pendTag_reg <= 1'b0;
			op_reg <= hit_test_pkg::OP_NONE;
			opnd_reg <= '0;
			newMode_reg <= hit_test_pkg::MODE_DRAW;
			wrEn_reg <= 1'b0;
			wrAddr_reg <= '0;
			wrData_reg <= '0;
			retValid_reg <= 1'b0;
			retCount_reg <= '0;
			badOp_reg <= 1'b0;
			under_reg <= 1'b0;
			over_reg <= 1'b0;
			fbEn_reg <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			mode_reg <= mode_next;
			configured_reg <= configured_next;
			base_reg <= base_next;
			ptr_reg <= ptr_next;
			size_reg <= size_next;
			used_reg <= used_next;
			records_reg <= records_next;
			ovf_reg <= ovf_next;
			hit_reg <= hit_next;
			word_reg <= word_next;
			pendTag_reg <= pendTag_next;
			op_reg <= op_next;
			opnd_reg <= opnd_next;
			newMode_reg <= newMode_next;
			wrEn_reg <= wrEn_next;
			wrAddr_reg <= wrAddr_next;
			wrData_reg <= wrData_next;
			retValid_reg <= retValid_next;
			retCount_reg <= retCount_next;
			badOp_reg <= badOp_next;
			under_reg <= under_next;
			over_reg <= over_next;
			fbEn_reg <= fbEn_next;
		end
	end

	always_comb begin
		cmdReady_next = (state_next == S_IDLE) && !accept;
	end

	always_ff @(posedge clk) begin
		if (!nrst) cmdReady <= 1'b0;
		else if (ce) cmdReady <= cmdReady_next;
	end

	assign mode = mode_reg;
	assign wrEn = wrEn_reg;
	assign wrAddr = wrAddr_reg;
	assign wrData = wrData_reg;
	assign retValid = retValid_reg;
	assign retCount = retCount_reg;
	assign badOpErr = badOp_reg;
	assign underflowErr = under_reg;
	assign overflowErr = over_reg;
	assign fbWriteEn = fbEn_reg;

	property p_no_fb;
		@(posedge clk) disable iff (!nrst)
		ce && inHit |=> !fbWriteEn;
	endproperty
	a_no_fb: assert property (p_no_fb) else $error("framebuffer write in hit mode");

	property p_reset_mode;
		@(posedge clk) $rose(nrst) |-> mode == hit_test_pkg::MODE_DRAW;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("mode not draw after reset");

	property p_no_write_outside;
		@(posedge clk) disable iff (!nrst)
		wrEn |-> used_reg <= size_reg;
	endproperty
	a_no_write_outside: assert property (p_no_write_outside) else $error("write past capacity");

	sequence s_consec;
		(ce && wrEn) ##1 wrEn;
	endsequence
	property p_consec;
		@(posedge clk) disable iff (!nrst)
		s_consec |-> wrAddr == $past(wrAddr) + 32'h00000001;
	endproperty
	a_consec: assert property (p_consec) else $error("record words not consecutive");

	property p_ovf_ret;
		@(posedge clk) disable iff (!nrst)
		retValid && $past(ovf_reg) |-> retCount == hit_test_pkg::COUNT_OVERFLOW && !ovf_reg;
	endproperty
	a_ovf_ret: assert property (p_ovf_ret) else $error("overflow not reported as -1");

	property p_stack_ignored;
		@(posedge clk) disable iff (!nrst)
		ce && !inHit && state_reg == S_IDLE && accept && !modeSwitch |=> state_reg == S_IDLE;
	endproperty
	a_stack_ignored: assert property (p_stack_ignored) else $error("stack op outside hit mode");
endmodule

//--- hit_test_pkg.sv
// shared constants and types for the hit-test tag recorder
package hit_test_pkg;
	localparam int TAG_W       = 32;
	localparam int STACK_DEPTH = 64;
	localparam int SP_W        = 7;
	localparam int ADDR_W      = 32;
	localparam int DEPTH_W     = 32;
	localparam logic [SP_W-1:0] SP_FULL = 7'h40;
	localparam logic [DEPTH_W-1:0] DEPTH_MAX = 32'hffffffff;
	localparam logic [DEPTH_W-1:0] DEPTH_MIN = 32'h00000000;
	localparam logic [31:0] COUNT_OVERFLOW = 32'hffffffff;
	localparam logic [2:0] HDR_WORDS = 3'h3;

	typedef enum logic [1:0] {
		MODE_DRAW,
		MODE_HIT,
		MODE_REPORT
	} mode_t;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_CLEAR,
		OP_POP,
		OP_PUSH,
		OP_REPLACE
	} tag_op_t;
endpackage

//--- tag_stack_if.sv
// tag stack command and state bundle
`timescale 1ns/1ps
interface tag_stack_if;
	hit_test_pkg::tag_op_t          op;
	logic [hit_test_pkg::TAG_W-1:0] operand;
	logic                           flush;
	logic [hit_test_pkg::SP_W-1:0]  count;
	logic [hit_test_pkg::SP_W-1:0]  rdIndex;
	logic [hit_test_pkg::TAG_W-1:0] rdData;
	logic                           underflow;
	logic                           overflow;
	logic                           badOp;

	modport ctrl (output op, output operand, output flush, output rdIndex,
		input count, input rdData, input underflow, input overflow, input badOp);
	modport stack (input op, input operand, input flush, input rdIndex,
		output count, output rdData, output underflow, output overflow, output badOp);
endinterface

//--- tag_stack.sv
// tag stack storage with push, pop, replace and clear
`timescale 1ns/1ps
module tag_stack (
	// clocking
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// command side
	tag_stack_if.stack ts
);
	logic [hit_test_pkg::TAG_W-1:0] mem_reg [hit_test_pkg::STACK_DEPTH];
	logic [hit_test_pkg::TAG_W-1:0] mem_next [hit_test_pkg::STACK_DEPTH];
	logic [hit_test_pkg::SP_W-1:0]  sp_reg;
	logic [hit_test_pkg::SP_W-1:0]  sp_next;

	always_comb begin
		mem_next = mem_reg;
		sp_next = sp_reg;
		ts.underflow = 1'b0;
		ts.overflow = 1'b0;
		ts.badOp = 1'b0;
		if (ts.flush) begin
			sp_next = '0;
		end else begin
			unique case (ts.op)
				hit_test_pkg::OP_NONE: ;
				hit_test_pkg::OP_CLEAR: sp_next = '0;
				hit_test_pkg::OP_POP: begin
					if (sp_reg == '0) ts.underflow = 1'b1;
					else sp_next = sp_reg - 7'h01;
				end
				hit_test_pkg::OP_PUSH: begin
					if (sp_reg == hit_test_pkg::SP_FULL) begin
						ts.overflow = 1'b1;
					end else begin
						mem_next[sp_reg[5:0]] = ts.operand;
						sp_next = sp_reg + 7'h01;
					end
				end
				hit_test_pkg::OP_REPLACE: begin
					if (sp_reg == '0) ts.badOp = 1'b1;
					else mem_next[sp_reg[5:0] - 6'h01] = ts.operand;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			sp_reg <= '0;
		end else if (ce) begin
			sp_reg <= sp_next;
			mem_reg <= mem_next;
		end
	end

	assign ts.count = sp_reg;
	assign ts.rdData = mem_reg[ts.rdIndex[5:0]];

	property p_push_grows;
		@(posedge clk) disable iff (!nrst)
		ce && !ts.flush && ts.op == hit_test_pkg::OP_PUSH && sp_reg < hit_test_pkg::SP_FULL
		|=> sp_reg == $past(sp_reg) + 7'h01;
	endproperty
	a_push_grows: assert property (p_push_grows) else $error("push did not grow stack");

	property p_pop_empty;
		@(posedge clk) disable iff (!nrst)
		!ts.flush && ts.op == hit_test_pkg::OP_POP && sp_reg == '0 |-> ts.underflow;
	endproperty
	a_pop_empty: assert property (p_pop_empty) else $error("no underflow on empty pop");

	property p_clear;
		@(posedge clk) disable iff (!nrst)
		ce && (ts.flush || ts.op == hit_test_pkg::OP_CLEAR) |=> sp_reg == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("stack not emptied");
endmodule

//--- depth_range.sv
// running min and max of window depth since last record
`timescale 1ns/1ps
module depth_range (
	// clocking
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// control
	input wire logic restart,
	input wire logic sampleValid,
	input wire logic [hit_test_pkg::DEPTH_W-1:0] sampleZ,
	// result
	output logic [hit_test_pkg::DEPTH_W-1:0] zMin,
	output logic [hit_test_pkg::DEPTH_W-1:0] zMax
);
	logic [hit_test_pkg::DEPTH_W-1:0] min_reg, min_next, max_reg, max_next;

	always_comb begin
		min_next = restart ? hit_test_pkg::DEPTH_MAX : min_reg;
		max_next = restart ? hit_test_pkg::DEPTH_MIN : max_reg;
		if (sampleValid) begin
			if (sampleZ < min_next) min_next = sampleZ;
			if (sampleZ > max_next) max_next = sampleZ;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			min_reg <= hit_test_pkg::DEPTH_MAX;
			max_reg <= hit_test_pkg::DEPTH_MIN;
		end else if (ce) begin
			min_reg <= min_next;
			max_reg <= max_next;
		end
	end

	assign zMin = min_reg;
	assign zMax = max_reg;

	property p_span;
		@(posedge clk) disable iff (!nrst)
		ce && sampleValid |=> zMin <= $past(sampleZ) && zMax >= $past(sampleZ);
	endproperty
	a_span: assert property (p_span) else $error("depth range misses vertex");
endmodule

//--- hit_cmd_source.sv
// command source model driving the recorder's command port
`timescale 1ns/1ps
module hit_cmd_source (
	// clocking
	input wire logic	clk,
	input wire logic	cmdReady,
	// command
	output logic	cmdValid,
	output hit_test_pkg::tag_op_t	tagOp,
	output logic [31:0]	tagOperand,
	output logic	modeSwitch,
	output hit_test_pkg::mode_t	modeSel,
	output logic	setBuffer,
	output logic [31:0]	bufBase,
	output logic [31:0]	bufSize
);
	initial begin
		cmdValid = 1'b0;
		tagOp = hit_test_pkg::OP_NONE;
		tagOperand = 32'h0;
		modeSwitch = 1'b0;
		modeSel = hit_test_pkg::MODE_DRAW;
		setBuffer = 1'b0;
		bufBase = 32'h0;
		bufSize = 32'h0;
	end
	// kind 0 tag op, 1 mode switch, 2 buffer setup; held until taken
	task automatic issue(input logic [1:0] kind, input hit_test_pkg::tag_op_t op,
		input hit_test_pkg::mode_t m, input logic [31:0] v, input logic [31:0] s,
		input logic [1:0] gap);
		repeat (gap) @(negedge clk);
		@(negedge clk);
		while (cmdReady !== 1'b1) @(negedge clk);
		cmdValid <= 1'b1;
		tagOp <= (kind == 2'h0) ? op : hit_test_pkg::OP_NONE;
		tagOperand <= v;
		modeSwitch <= (kind == 2'h1);
		modeSel <= m;
		setBuffer <= (kind == 2'h2);
		bufBase <= v;
		bufSize <= s;
		@(posedge clk);
		@(negedge clk);
		// released operand and buffer fields show inverted values, strobes clear; modeSel keeps its last one
		cmdValid <= 1'b0;
		tagOp <= hit_test_pkg::OP_NONE;
		modeSwitch <= 1'b0;
		setBuffer <= 1'b0;
		tagOperand <= ~v;
		bufBase <= ~v;
		bufSize <= ~s;
	endtask
endmodule

//--- hit_test_tag_recorder_bench.sv
// self-checking bench for the hit-test tag recorder
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		nCompared++; \
		if ((got) !== (exp)) begin \
			failCount++; \
			$display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp); \
		end \
	end
module hit_test_tag_recorder_bench;
	logic	clk = 1'b0;
	logic	nrst = 1'b0;
	logic	ce = 1'b1;
	logic	primValid = 1'b0, primInClip = 1'b0, primCulled = 1'b0;
	logic	windowPoint = 1'b0, vertexValid = 1'b0, fbWriteReq = 1'b0;
	logic [31:0]	vertexZ = 32'h0;
	logic	cmdValid, modeSwitch, setBuffer, cmdReady, fbWriteEn, wrEn;
	logic	retValid, badOpErr, underflowErr, overflowErr;
	hit_test_pkg::tag_op_t	tagOp;
	hit_test_pkg::mode_t	modeSel, mode;
	logic [31:0]	tagOperand, bufBase, bufSize, wrAddr, wrData, retCount;
	logic [63:0]	expWr[$];
	logic [31:0]	expRet[$], stk[$];
	logic [31:0]	base, size, ptr, nRec = 32'h0, zLo = 32'hffffffff, zHi = 32'h0;
	logic	pend = 1'b0, ovf = 1'b0, inHit = 1'b0, cfg = 1'b0;
	int	badE, undE, ovfE, badN, undN, ovfN, failCount, nCompared, cyc;
	logic [15:0]	lfsr = 16'h0041;

	hit_test_tag_recorder u_dut (
		.clk(clk), .nrst(nrst), .ce(ce), .cmdValid(cmdValid), .tagOp(tagOp),
		.tagOperand(tagOperand), .modeSwitch(modeSwitch), .modeSel(modeSel),
		.setBuffer(setBuffer), .bufBase(bufBase), .bufSize(bufSize), .cmdReady(cmdReady),
		.primValid(primValid), .primInClip(primInClip), .primCulled(primCulled),
		.windowPoint(windowPoint), .vertexValid(vertexValid), .vertexZ(vertexZ),
		.fbWriteReq(fbWriteReq), .fbWriteEn(fbWriteEn), .wrEn(wrEn), .wrAddr(wrAddr),
		.wrData(wrData), .mode(mode), .retValid(retValid), .retCount(retCount),
		.badOpErr(badOpErr), .underflowErr(underflowErr), .overflowErr(overflowErr)
	);
	hit_cmd_source u_src (
		.clk(clk), .cmdReady(cmdReady), .cmdValid(cmdValid), .tagOp(tagOp),
		.tagOperand(tagOperand), .modeSwitch(modeSwitch), .modeSel(modeSel),
		.setBuffer(setBuffer), .bufBase(bufBase), .bufSize(bufSize)
	);

	initial begin
		forever #4 clk = ~clk;
	end

	function automatic logic [31:0] rnd32();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return {lfsr, ~lfsr};
	endfunction

	task automatic endSim();
		$display("compared %0d, mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failCount++;
			endSim();
		end
	end

	// result watcher: oldest note against each write and return; error pulses only counted
	always @(negedge clk) begin
		logic [63:0] e;
		if (badOpErr === 1'b1) badN++;
		if (underflowErr === 1'b1) undN++;
		if (overflowErr === 1'b1) ovfN++;
		if (wrEn === 1'b1) begin
			e = (expWr.size() != 0) ? expWr.pop_front() : 'x;
			`CHK({wrAddr, wrData}, e)
		end
		if (retValid === 1'b1) begin
			e = (expRet.size() != 0) ? {32'h0, expRet.pop_front()} : 'x;
			`CHK({32'h0, retCount}, e)
		end
	end

	task automatic idle();
		@(negedge clk);
		while (cmdReady !== 1'b1) @(negedge clk);
	endtask

	task automatic note();
		logic [31:0] w[$];
		if (pend) begin
			w.push_back(32'(stk.size()));
			w.push_back(zLo);
			w.push_back(zHi);
			foreach (stk[i]) w.push_back(stk[i]);
			foreach (w[i]) begin
				if (ptr < base + size) expWr.push_back({ptr, w[i]});
				else ovf = 1'b1;
				ptr = ptr + 32'h1;
			end
			nRec = nRec + 32'h1;
		end
		pend = 1'b0;
		zLo = 32'hffffffff;
		zHi = 32'h0;
	endtask

	task automatic tag(input hit_test_pkg::tag_op_t op, input logic [31:0] v);
		if (inHit) begin
			note();
			case (op)
				hit_test_pkg::OP_CLEAR: stk.delete();
				hit_test_pkg::OP_POP: begin
					if (stk.size() == 0) undE++;
					else void'(stk.pop_back());
				end
				hit_test_pkg::OP_PUSH: begin
					if (stk.size() == hit_test_pkg::STACK_DEPTH) ovfE++;
					else stk.push_back(v);
				end
				default: begin
					if (stk.size() == 0) badE++;
					else stk[stk.size() - 1] = v;
				end
			endcase
		end
		u_src.issue(2'h0, op, hit_test_pkg::MODE_DRAW, v, 32'h0, lfsr[1:0]);
	endtask

	task automatic sw(input hit_test_pkg::mode_t m);
		if (inHit) begin
			note();
			expRet.push_back(ovf ? 32'hffffffff : nRec);
		end
		if (m == hit_test_pkg::MODE_HIT) begin
			if (!cfg) badE++;
			ptr = base;
			ovf = 1'b0;
			nRec = 32'h0;
			pend = 1'b0;
		end
		inHit = (m == hit_test_pkg::MODE_HIT);
		stk.delete();
		u_src.issue(2'h1, hit_test_pkg::OP_NONE, m, 32'h0, 32'h0, lfsr[1:0]);
		idle();
		`CHK(mode, m)
	endtask

	task automatic setb(input logic [31:0] b, input logic [31:0] s);
		if (inHit) badE++;
		else begin
			base = b;
			size = s;
			cfg = 1'b1;
		end
		u_src.issue(2'h2, hit_test_pkg::OP_NONE, hit_test_pkg::MODE_DRAW, b, s, lfsr[1:0]);
	endtask

	task automatic prim(input logic inC, input logic cul, input logic win, input logic [31:0] z);
		idle();
		primValid <= !win;
		primInClip <= inC;
		primCulled <= cul;
		windowPoint <= win;
		vertexValid <= !win;
		vertexZ <= z;
		if (inHit && ((inC && !cul) || win)) pend = 1'b1;
		if (inHit && inC && !cul && !win && z < zLo) zLo = z;
		if (inHit && inC && !cul && !win && z > zHi) zHi = z;
		@(negedge clk);
		primValid <= 1'b0;
		windowPoint <= 1'b0;
		vertexValid <= 1'b0;
		vertexZ <= ~z;
	endtask

	task automatic fb(input logic e);
		idle();
		fbWriteReq <= 1'b1;
		@(negedge clk);
		fbWriteReq <= 1'b0;
		`CHK(fbWriteEn, e)
	endtask

	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		`CHK(mode, hit_test_pkg::MODE_DRAW)
		fb(1'b1);
		tag(hit_test_pkg::OP_POP, 32'h0);
		sw(hit_test_pkg::MODE_HIT);
		sw(hit_test_pkg::MODE_DRAW);
		setb(32'h100, 32'h6);
		sw(hit_test_pkg::MODE_HIT);
		fb(1'b0);
		tag(hit_test_pkg::OP_PUSH, rnd32());
		prim(1'b1, 1'b0, 1'b0, 32'h50);
		prim(1'b1, 1'b0, 1'b0, 32'h9);
		prim(1'b0, 1'b0, 1'b0, 32'h1);
		prim(1'b1, 1'b1, 1'b0, 32'h0);
		tag(hit_test_pkg::OP_PUSH, rnd32());
		prim(1'b1, 1'b1, 1'b0, 32'h2);
		tag(hit_test_pkg::OP_POP, 32'h0);
		prim(1'b0, 1'b0, 1'b1, 32'h7);
		tag(hit_test_pkg::OP_REPLACE, rnd32());
		sw(hit_test_pkg::MODE_DRAW);
		sw(hit_test_pkg::MODE_HIT);
		tag(hit_test_pkg::OP_PUSH, rnd32());
		tag(hit_test_pkg::OP_CLEAR, 32'h0);
		prim(1'b1, 1'b0, 1'b0, rnd32());
		tag(hit_test_pkg::OP_POP, 32'h0);
		tag(hit_test_pkg::OP_REPLACE, rnd32());
		setb(32'h200, 32'h8);
		repeat (65) tag(hit_test_pkg::OP_PUSH, rnd32());
		prim(1'b1, 1'b0, 1'b0, rnd32());
		sw(hit_test_pkg::MODE_REPORT);
		sw(hit_test_pkg::MODE_HIT);
		tag(hit_test_pkg::OP_POP, 32'h0);
		tag(hit_test_pkg::OP_PUSH, rnd32());
		tag(hit_test_pkg::OP_PUSH, rnd32());
		prim(1'b1, 1'b0, 1'b0, rnd32());
		sw(hit_test_pkg::MODE_DRAW);
		tag(hit_test_pkg::OP_PUSH, rnd32());
		sw(hit_test_pkg::MODE_HIT);
		prim(1'b1, 1'b0, 1'b0, rnd32());
		tag(hit_test_pkg::OP_POP, 32'h0);
		sw(hit_test_pkg::MODE_DRAW);
		repeat (4) @(negedge clk);
		`CHK(expWr.size(), 0)
		`CHK(expRet.size(), 0)
		`CHK(badN, badE)
		`CHK(undN, undE)
		`CHK(ovfN, ovfE)
		endSim();
	end
endmodule
